// ===== design/sslp_regs.svh
// Named constants for the sleep-mode control block.
// Assumes a 100 MHz system clock; included by the package, sslp_ctrl and the bench.
`ifndef SSLP_REGS_SVH
`define SSLP_REGS_SVH
`define SSLP_CLK_PERIOD_PS   32'd10000
`define SSLP_ENTRY_CYCLES    2'd2
`define SSLP_RECOVERY_PS     32'd20000
`define SSLP_RECOVERY_CYCLES ((`SSLP_RECOVERY_PS + `SSLP_CLK_PERIOD_PS - 32'd1) / `SSLP_CLK_PERIOD_PS)
`define SSLP_CNT_W           4
`define SSLP_ADDR_W          18
`define SSLP_DATA_W          36
`define SSLP_BURST_W         2
`define SSLP_ZERO_ADDR       18'h0_0000
`define SSLP_ZERO_DATA       36'h0_0000_0000
`define SSLP_ZERO_CNT        4'h0
`endif

// ===== design/sslp_pkg.sv
// Types shared by the sleep-mode control block.
// Assumes sslp_regs.svh is on the include path.
`include "sslp_regs.svh"
package sslp_pkg;
  typedef enum logic [1:0] {
    SSLP_AWAKE,
    SSLP_ENTERING,
    SSLP_ASLEEP,
    SSLP_RECOVER
  } sslp_state_t;

  typedef enum logic [1:0] {
    SSLP_CMD_DESELECT,
    SSLP_CMD_READ,
    SSLP_CMD_WRITE,
    SSLP_CMD_CONTINUE
  } sslp_cmd_kind_t;

  typedef struct packed {
    sslp_cmd_kind_t             kind;
    logic [`SSLP_ADDR_W-1:0]    addr;
    logic [`SSLP_DATA_W-1:0]    wdata;
    logic                       oe_n;
  } sslp_cmd_t;

  typedef struct packed {
    logic [`SSLP_DATA_W-1:0]    data;
    logic                       data_oe;
  } sslp_dq_t;
endpackage

// ===== design/sslp_sync.sv
// Two-flop synchroniser for the asynchronous sleep request.
// Assumes the input may change at any time relative to the clock.
`timescale 1ns/1ps
module sslp_sync (
  input  wire logic i_sys_clk,  // System clock.
  input  wire logic i_reset,    // Synchronous reset, active high.
  input  wire logic i_async,    // Asynchronous level.
  output logic      o_sync      // Synchronised level.
);
  logic meta_reg;
  logic sync_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;
endmodule

// ===== design/sslp_ctrl.sv
// Sleep-mode controller and simplified burst-SRAM core behind the pins.
// Assumes commands are sampled on the clock and the host keeps its own duties.
// Operation
// - The sleep request is low in normal use and an undriven pin reads low; the model has no pull-down and relies on the host driving it low.
// - The sleep request is an asynchronous active-high command to sleep.
// - The device enters sleep two clocks after the request is seen high.
// - Memory contents and internal state are retained through sleep.
// - While asleep the device is deselected, ignores inputs and floats its outputs.
// - Sleep lasts exactly while the request stays high, with no timeout.
// - After the request falls, normal service resumes only after at least 20 ns; the core serves reads during recovery and drops only writes.
// - A dummy read advances the burst counter exactly like a normal read.
`timescale 1ns/1ps
`include "sslp_regs.svh"
module sslp_ctrl (
  input  wire logic               i_sys_clk,        // System clock, 100 MHz.
  input  wire logic               i_reset,          // Synchronous reset, active high.
  input  wire logic               i_sleep_request,  // Asynchronous sleep request, active high.
  input  wire sslp_pkg::sslp_cmd_t i_cmd,           // Command sampled each clock.
  output sslp_pkg::sslp_dq_t      o_dq,             // Read data and its output enable.
  output logic                    o_asleep,         // High while in the sleep state.
  output logic                    o_ready           // High while normal service is available.
);
  import sslp_pkg::*;

  localparam int RECOVERY_CYCLES = `SSLP_RECOVERY_CYCLES;

  logic                       sleep_sync;
  sslp_state_t                state_reg;
  sslp_state_t                state_next;
  logic [`SSLP_CNT_W-1:0]     cnt_reg;
  logic [`SSLP_CNT_W-1:0]     cnt_next;
  logic [`SSLP_ADDR_W-1:0]    addr_reg;
  logic [`SSLP_BURST_W-1:0]   burst_reg;
  logic [`SSLP_DATA_W-1:0]    rdata_reg;
  logic                       rvalid_reg;
  sslp_dq_t                   dq_reg;
  logic                       asleep_reg;
  logic                       ready_reg;
  logic [`SSLP_DATA_W-1:0]    mem [0:(1<<`SSLP_ADDR_W)-1];

  // The pin pull-down is not modelled here; the host model drives the request low from time zero, and an undriven level is not read as low.
  sslp_sync u_sync (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_async   (i_sleep_request),
    .o_sync    (sleep_sync)
  );

  wire logic entry_done = (cnt_reg == `SSLP_CNT_W'(`SSLP_ENTRY_CYCLES - 2'd1));
  wire logic recov_done = (cnt_reg == `SSLP_CNT_W'(RECOVERY_CYCLES - 1));
  wire logic serving    = (state_reg == SSLP_AWAKE) || (state_reg == SSLP_RECOVER)
                          || (state_reg == SSLP_ENTERING);
  // Writes in recovery are the host's fault; they are dropped rather than risk a bad cell.
  wire logic wr_ok      = (state_reg == SSLP_AWAKE) || (state_reg == SSLP_ENTERING);
  wire logic is_read    = serving && (i_cmd.kind == SSLP_CMD_READ);
  wire logic is_write   = wr_ok && (i_cmd.kind == SSLP_CMD_WRITE);
  wire logic is_cont    = serving && (i_cmd.kind == SSLP_CMD_CONTINUE);
  wire logic [`SSLP_BURST_W-1:0] burst_inc = burst_reg + `SSLP_BURST_W'(1);
  wire logic [`SSLP_ADDR_W-1:0]  cur_addr  = is_cont
                          ? {addr_reg[`SSLP_ADDR_W-1:`SSLP_BURST_W], burst_inc} : i_cmd.addr;

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      SSLP_AWAKE: begin
        if (sleep_sync) begin
          state_next = SSLP_ENTERING;
          cnt_next   = `SSLP_ZERO_CNT;
        end
      end
      SSLP_ENTERING: begin
        if (!sleep_sync) begin
          state_next = SSLP_AWAKE;
        end else if (entry_done) begin
          state_next = SSLP_ASLEEP;
        end else begin
          cnt_next = cnt_reg + `SSLP_CNT_W'(1);
        end
      end
      SSLP_ASLEEP: begin
        if (!sleep_sync) begin
          state_next = SSLP_RECOVER;
          cnt_next   = `SSLP_ZERO_CNT;
        end
      end
      SSLP_RECOVER: begin
        if (sleep_sync) begin
          state_next = SSLP_ENTERING;
          cnt_next   = `SSLP_ZERO_CNT;
        end else if (recov_done) begin
          state_next = SSLP_AWAKE;
        end else begin
          cnt_next = cnt_reg + `SSLP_CNT_W'(1);
        end
      end
      default: begin
        state_next = SSLP_AWAKE;
        cnt_next   = `SSLP_ZERO_CNT;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state_reg <= SSLP_AWAKE;
      cnt_reg   <= `SSLP_ZERO_CNT;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // Memory has no reset and is untouched while asleep, so contents survive.
  always_ff @(posedge i_sys_clk) begin
    if (is_write) begin
      mem[cur_addr] <= i_cmd.wdata;
    end
  end

  // A dummy read steps the burst counter like any read; oe only gates the drivers.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      addr_reg  <= `SSLP_ZERO_ADDR;
      burst_reg <= '0;
    end else if (is_read || is_write) begin
      addr_reg  <= i_cmd.addr;
      burst_reg <= i_cmd.addr[`SSLP_BURST_W-1:0];
    end else if (is_cont) begin
      burst_reg <= burst_inc;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      rdata_reg  <= `SSLP_ZERO_DATA;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg  <= (is_read || is_cont) ? mem[cur_addr] : rdata_reg;
      rvalid_reg <= (is_read || is_cont) && !i_cmd.oe_n;
    end
  end

  // Sleep forces deselect: drivers off and no command acted on.
  // The next state is used so that a read launched while entering stays off the pins in the first sleeping cycle.
  wire logic drive_next = rvalid_reg && (state_next != SSLP_ASLEEP) && !i_cmd.oe_n;

  logic [`SSLP_DATA_W-1:0]    dq_data_next;

  // Each pin is gated on its own, so an idle bus always shows zero instead of stale read data.
  for (genvar b = 0; b < `SSLP_DATA_W; b++) begin : g_dq_gate
    assign dq_data_next[b] = drive_next && rdata_reg[b];
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      dq_reg     <= '0;
      asleep_reg <= 1'b0;
      ready_reg  <= 1'b0;
    end else begin
      dq_reg.data    <= dq_data_next;
      dq_reg.data_oe <= drive_next;
      asleep_reg     <= (state_next == SSLP_ASLEEP);
      ready_reg      <= (state_next == SSLP_AWAKE);
    end
  end

  // The host waits for idle before asking to sleep; commands in flight are not protected.
  // Read-to-write turnaround by dummy reads is the host's job; the core just honours oe.
  assign o_dq     = dq_reg;
  assign o_asleep = asleep_reg;
  assign o_ready  = ready_reg;
endmodule

// ===== tb/sslp_ctrl_sva.sv
// Checker for the sleep-mode pins.
// Assumes it is bound to sslp_ctrl.
`timescale 1ns/1ps
module sslp_ctrl_sva (
  input wire logic                i_sys_clk,       // Clock.
  input wire logic                i_reset,         // Reset.
  input wire logic                i_sleep_request, // Sleep.
  input wire sslp_pkg::sslp_cmd_t i_cmd,           // Command.
  input wire sslp_pkg::sslp_dq_t  o_dq,            // Data.
  input wire logic                o_asleep,        // Asleep.
  input wire logic                o_ready          // Ready.
);
  import sslp_pkg::*;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  a_entry_late: assert property (i_sleep_request [*8] |-> o_asleep) else $error("late sleep");
  a_entry_early: assert property ($rose(i_sleep_request) && !o_asleep |=> !o_asleep [*2]) else $error("early");
  a_ready_drop: assert property (i_sleep_request [*6] |-> !o_ready) else $error("ready kept");
  a_asleep_float: assert property (o_asleep |-> !o_dq.data_oe) else $error("drives asleep");
  // The request reaches the state machine through two flops, so the level two samples back is what counts.
  a_sleep_held: assert property (o_asleep && $past(i_sleep_request, 2)
    |=> o_asleep) else $error("woke early");
  a_wake_wait: assert property ($fell(o_asleep) |-> !o_ready ##1 !o_ready) else $error("short recovery");
  a_dummy_quiet: assert property (i_cmd.oe_n [*2] |=> !o_dq.data_oe) else $error("dummy drove");
  a_read_lat: assert property (o_ready && i_cmd.kind == SSLP_CMD_READ && !i_cmd.oe_n ##1 !i_cmd.oe_n
    |=> o_dq.data_oe) else $error("no read data");
  a_idle_zero: assert property (!o_dq.data_oe |-> o_dq.data == '0) else $error("data not zero");
  c_asleep: cover property (o_asleep);
  c_wake: cover property ($fell(o_asleep));
  c_read: cover property (o_dq.data_oe);
endmodule
bind sslp_ctrl sslp_ctrl_sva sslp_ctrl_sva_inst (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
  .i_sleep_request(i_sleep_request), .i_cmd(i_cmd), .o_dq(o_dq), .o_asleep(o_asleep), .o_ready(o_ready));

// ===== tb/sslp_host_model.sv
// Host controller model driving sleep and commands.
// Assumes callers sequence accesses around sleep.
`timescale 1ns/1ps
module sslp_host_model (
  input  wire logic          i_sys_clk,       // Clock.
  output sslp_pkg::sslp_cmd_t o_cmd,          // Command.
  output logic               o_sleep_request  // Sleep.
);
  import sslp_pkg::*;
  initial begin
    o_cmd = '0;
    o_sleep_request = 1'b0;
  end
  task automatic issue(input sslp_cmd_kind_t k, input logic [17:0] a, input logic [35:0] d, input logic oe_n);
    @(posedge i_sys_clk);
    o_cmd <= '{kind: k, addr: a, wdata: d, oe_n: oe_n};
  endtask
  // Only deselects around a change, so no access is caught mid-flight.
  task automatic set_sleep(input logic lvl);
    @(posedge i_sys_clk);
    o_cmd <= '{kind: SSLP_CMD_DESELECT, addr: '0, wdata: '0, oe_n: 1'b1};
    o_sleep_request <= lvl;
  endtask
endmodule

// ===== tb/sslp_tb_top.sv
// Bench for the sleep-mode control block.
// Assumes the design and host model are compiled first.
`timescale 1ns/1ps
`include "sslp_regs.svh"
module sram_sleep_mode_control_tb_top;
  import sslp_pkg::*;
  // Two synchroniser flops plus the state register's step into entering or recovery.
  localparam int SYNC_LAT = 3;
  logic      i_sys_clk;
  logic      i_reset;
  logic      i_sleep_request;
  sslp_cmd_t i_cmd;
  sslp_dq_t  o_dq;
  logic      o_asleep;
  logic      o_ready;
  int        n_errors;
  int        tests_run;
  sslp_ctrl sslp_ctrl_inst (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_sleep_request(i_sleep_request),
    .i_cmd(i_cmd), .o_dq(o_dq), .o_asleep(o_asleep), .o_ready(o_ready));
  sslp_host_model sslp_host_model_inst (.i_sys_clk(i_sys_clk), .o_cmd(i_cmd), .o_sleep_request(i_sleep_request));
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [17:0] a, input logic [35:0] d);
    sslp_host_model_inst.issue(SSLP_CMD_WRITE, a, d, 1'b1);
  endtask
  task automatic rd(input sslp_cmd_kind_t k, input logic [17:0] a, input logic oe_n, input logic eo,
                    input logic [35:0] exp);
    sslp_host_model_inst.issue(k, a, '0, oe_n);
    sslp_host_model_inst.issue(SSLP_CMD_DESELECT, a, '0, oe_n);
    @(posedge i_sys_clk);
    #1;
    check("dq_oe", 36'(o_dq.data_oe), 36'(eo));
    check("dq_data", o_dq.data, exp);
  endtask
  task automatic t_burst();
    wr(18'h0_0004, 36'h5_a5a5_a5a5);
    wr(18'h0_0005, 36'hc_3c3c_3c3c);
    rd(SSLP_CMD_READ, 18'h0_0005, 1'b0, 1'b1, 36'hc_3c3c_3c3c);
    rd(SSLP_CMD_READ, 18'h0_0004, 1'b1, 1'b0, '0);
    rd(SSLP_CMD_CONTINUE, '0, 1'b0, 1'b1, 36'hc_3c3c_3c3c);
  endtask
  task automatic t_sleep();
    int n;
    wr(18'h0_0008, 36'h9_0f0f_0f0f);
    sslp_host_model_inst.set_sleep(1'b1);
    n = 0;
    while (o_asleep !== 1'b1 && n < 20) begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    check("asleep", 36'(o_asleep), 36'h1);
    check("entry_cycles", 36'(n), 36'(SYNC_LAT + `SSLP_ENTRY_CYCLES));
    wr(18'h0_0008, 36'h1_2345_6789);
    rd(SSLP_CMD_READ, 18'h0_0008, 1'b0, 1'b0, '0);
    repeat (40) @(posedge i_sys_clk);
    #1;
    check("held", 36'(o_asleep), 36'h1);
    sslp_host_model_inst.set_sleep(1'b0);
    n = 0;
    while (o_ready !== 1'b1 && n < 20) begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    check("recovery", 36'(n), 36'(SYNC_LAT + `SSLP_RECOVERY_CYCLES));
    rd(SSLP_CMD_READ, 18'h0_0008, 1'b0, 1'b1, 36'h9_0f0f_0f0f);
  endtask
  initial begin
    n_errors = 0;
    tests_run = 0;
    i_reset = 1'b1;
    repeat (20) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    t_burst();
    t_sleep();
    complete_run();
  end
  initial begin
    repeat (2000) @(posedge i_sys_clk);
    n_errors++;
    complete_run();
  end
endmodule
